// [core/ssd_pkg.sv]
// Purpose: shared constants and types for the servo serial command decoder
// Assumes: frames are already split into fields by an upstream framer
// Notes: all values ASCII or binary as noted

package ssd_pkg;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_CUR_ALARM = 8'h02;
	localparam logic [7:0] CMD_IO_READ = 8'h12;
	localparam logic [7:0] CMD_GROUP = 8'h1F;
	localparam logic [7:0] CMD_HIST = 8'h33;
	localparam logic [7:0] CMD_SNAP = 8'h35;
	localparam logic [7:0] CMD_LATCH = 8'h6C;
	localparam logic [7:0] CMD_GEN_R = 8'h6D;
	localparam logic [7:0] CMD_GEN_D = 8'h6E;
	localparam logic [7:0] CMD_SNAP_CLR = 8'h81;
	localparam logic [7:0] CMD_ALARM_CLR = 8'h82;
	localparam logic [7:0] CMD_PARAM_WR = 8'h84;
	localparam logic [7:0] CMD_COMM_IN = 8'h92;

	// ------------------------------------------------------------
	// data numbers
	// ------------------------------------------------------------
	localparam logic [7:0] DN_ZERO = 8'h00;
	localparam logic [7:0] DN_LATCH = 8'h01;
	localparam logic [7:0] DN_HIST_NUM = 8'h10;
	localparam logic [7:0] DN_HIST_TIME = 8'h20;
	localparam logic [7:0] DN_IN_PIN = 8'h40;
	localparam logic [7:0] DN_COMM_IN = 8'h60;
	localparam logic [7:0] DN_VERSION = 8'h70;
	localparam logic [7:0] DN_OUT_DEV = 8'h80;
	localparam logic [7:0] DN_OUT_PIN = 8'hC0;
	localparam logic [3:0] DN_SNAP_LO = 4'h8;
	localparam logic [3:0] DN_SNAP_HI = 4'h9;
	localparam logic [4:0] SNAP_HI_BASE = 5'h10;

	// ------------------------------------------------------------
	// sizes, key, lengths, positions, reset values
	// ------------------------------------------------------------
	localparam int HIST_DEPTH = 6;
	localparam int SNAP_DEPTH = 18;
	localparam int GEN_DEPTH = 4;
	localparam logic [15:0] CLEAR_KEY = 16'h1EA5;
	localparam logic [4:0] LEN_NONE = 5'h00;
	localparam logic [4:0] LEN_4 = 5'h04;
	localparam logic [4:0] LEN_8 = 5'h08;
	localparam logic [4:0] LEN_12 = 5'h0C;
	localparam logic [4:0] LEN_16 = 5'h10;
	localparam logic [4:0] POS_STATION = 5'h01;
	localparam logic [4:0] POS_ERR = 5'h02;
	localparam logic [4:0] POS_DATA = 5'h03;
	localparam logic [31:0] COMM_IN_RST = 32'h00000000;
	localparam logic [15:0] ALARM_NONE = 16'h0000;

	// ------------------------------------------------------------
	// characters and error letters (upper case)
	// ------------------------------------------------------------
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] ERR_OK = 8'h41;
	localparam logic [7:0] ERR_PARITY = 8'h42;
	localparam logic [7:0] ERR_SUM = 8'h43;
	localparam logic [7:0] ERR_CHAR = 8'h44;
	localparam logic [7:0] ERR_CMD = 8'h45;
	localparam logic [7:0] ERR_DN = 8'h46;
	localparam logic [7:0] CASE_BIT = 8'h20;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] cmd;
		logic [7:0] dataNo;
		logic [31:0] data;
		logic parityErr;
		logic sumErr;
		logic charErr;
	} ssd_req_s;

	typedef struct packed {
		logic [31:0] inDev;
		logic [31:0] inPin;
		logic [31:0] outDev;
		logic [31:0] outPin;
		logic [31:0] latchPos;
		logic [15:0] group;
	} ssd_io_s;

	typedef struct packed {
		logic evt;
		logic [15:0] code;
		logic [31:0] stamp;
	} ssd_alarm_s;

	typedef enum logic [1:0] {
		SSD_IDLE = 2'b01,
		SSD_SEND = 2'b10
	} ssd_state_e;

	function automatic logic [7:0] ssd_hex_ascii(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

endpackage

// [core/ssd_checksum.sv]
// Purpose: running 8-bit sum of the transmitted frame characters
// Assumes: clear and add are never needed in the same cycle
// Notes: sum wraps, only the low byte is kept

`timescale 1ns/1ns

module ssd_checksum
	import ssd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] chr,
	// result
	output logic [7:0] sum
);

	always_ff @(posedge clk) begin
		if (sys_rst || clear) begin
			sum <= 8'h00;
		end else if (add) begin
			sum <= sum + chr;
		end
	end

endmodule

// [core/ssd_command_decoder.sv]
// Purpose: slave-side command decoder and response framer of the servo serial link
// Assumes: an upstream framer delivers command, data number, data and error flags
// Notes: response leaves one character per accepted txReady
//
// Operation
// - command 12 returns 8 chars: devices 00, pins 40, comm 60, outputs 80, C0.
// - command 33 data 10..15 returns 4-char alarm numbers, newest first.
// - command 33 data 20..25 returns 8-char alarm times, newest first.
// - command 02 data 00 returns current alarm number, 4 chars.
// - command 35 data 80..91 returns 12-char status captured at alarm.
// - command 6C data 01 returns latched position, 8 chars.
// - command 6D data 01..04 returns first-bank register, 8 chars.
// - command 6E data 01..04 returns second-bank register, 8 chars.
// - command 1F data 00 returns group setting, 4 chars.
// - command 02 data 70 returns software version, 16 chars.
// - command 81 data 00 with key 1EA5 clears status snapshot.
// - command 84 writes parameter numbered by the data number value.
// - command 92 data 60 sets communication-driven inputs.
// - command 82 data 20 with key 1EA5 erases alarm history.
// - command 82 data 00 with key 1EA5 resets active alarm.
// - response error letter A..F, lower case while an alarm is active.
// - checksum is low byte of char sum after STX through ETX.

`timescale 1ns/1ns

module ssd_command_decoder
	import ssd_pkg::*;
#(
	parameter logic [63:0] SW_VERSION = 64'h0123456789ABCDEF // arbitrary value
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// request from framer
	input wire ssd_req_s req,
	output logic reqReady,
	// device state
	input wire ssd_io_s io,
	input wire logic [GEN_DEPTH-1:0][31:0] genR,
	input wire logic [GEN_DEPTH-1:0][31:0] genD,
	input wire ssd_alarm_s alarm,
	input wire logic snapWe,
	input wire logic [4:0] snapIdx,
	input wire logic [47:0] snapVal,
	// response stream
	input wire logic [3:0] stationNo,
	input wire logic txReady,
	output logic txValid,
	output logic [7:0] txChar,
	// write effects
	output logic [31:0] commInput,
	output logic paramWe,
	output logic [7:0] paramNum,
	output logic [31:0] paramVal,
	output logic alarmActive
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	ssd_state_e state;
	logic [4:0] pos;
	logic [7:0] respErr;
	logic [4:0] respLen;
	logic [63:0] respVal;
	logic [15:0] curAlarm;
	logic [15:0] histNum [HIST_DEPTH];
	logic [31:0] histTime [HIST_DEPTH];
	logic [47:0] snap [SNAP_DEPTH];
	logic [7:0] chkSum;

	logic accept;
	logic frameOk;
	logic keyOk;
	logic dnBad;
	logic doSnapClr, doHistClr, doAlarmRst, doParam, doComm;
	logic snapClrGo, histClrGo, alarmRstGo, paramGo, commGo;
	logic [7:0] next_err;
	logic [4:0] next_len;
	logic [63:0] next_val;
	logic [4:0] snapSel;
	logic [4:0] etxPos;
	logic [4:0] lastPos;
	logic [4:0] next_pos;
	logic [4:0] nibShift;
	logic [63:0] shifted;
	logic [7:0] sumWithEtx;
	logic [7:0] next_char;
	logic chkAdd;

	function automatic logic genOk(input logic [7:0] dn);
		return (dn >= 8'h01) && (dn <= 8'h04);
	endfunction

	function automatic logic [1:0] genIdx(input logic [7:0] dn);
		return 2'(dn[1:0] - 2'h1);
	endfunction

	assign accept = req.valid && (state == SSD_IDLE);
	assign frameOk = !req.parityErr && !req.sumErr && !req.charErr;
	assign keyOk = (req.data[15:0] == CLEAR_KEY);
	assign snapClrGo = accept && doSnapClr;
	assign histClrGo = accept && doHistClr;
	assign alarmRstGo = accept && doAlarmRst;
	assign paramGo = accept && doParam;
	assign commGo = accept && doComm;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	always_comb begin
		next_err = ERR_OK;
		next_len = LEN_NONE;
		next_val = 64'h0;
		dnBad = 1'b0;
		doSnapClr = 1'b0;
		doHistClr = 1'b0;
		doAlarmRst = 1'b0;
		doParam = 1'b0;
		doComm = 1'b0;
		snapSel = {1'b0, req.dataNo[3:0]};
		if (req.parityErr) begin
			next_err = ERR_PARITY;
		end else if (req.sumErr) begin
			next_err = ERR_SUM;
		end else if (req.charErr) begin
			next_err = ERR_CHAR;
		end else begin
			case (req.cmd)
				CMD_IO_READ: begin
					next_len = LEN_8;
					if (req.dataNo == DN_ZERO) next_val = {32'h0, io.inDev};
					else if (req.dataNo == DN_IN_PIN) next_val = {32'h0, io.inPin};
					else if (req.dataNo == DN_COMM_IN) next_val = {32'h0, commInput};
					else if (req.dataNo == DN_OUT_DEV) next_val = {32'h0, io.outDev};
					else if (req.dataNo == DN_OUT_PIN) next_val = {32'h0, io.outPin};
					else dnBad = 1'b1;
				end
				CMD_HIST: begin
					if (req.dataNo[7:4] == DN_HIST_NUM[7:4] && req.dataNo[3:0] < 4'h6) begin
						next_len = LEN_4;
						next_val = {48'h0, histNum[req.dataNo[2:0]]};
					end else if (req.dataNo[7:4] == DN_HIST_TIME[7:4] && req.dataNo[3:0] < 4'h6) begin
						next_len = LEN_8;
						next_val = {32'h0, histTime[req.dataNo[2:0]]};
					end else begin
						dnBad = 1'b1;
					end
				end
				CMD_CUR_ALARM: begin
					if (req.dataNo == DN_ZERO) begin
						next_len = LEN_4;
						next_val = {48'h0, curAlarm};
					end else if (req.dataNo == DN_VERSION) begin
						next_len = LEN_16;
						next_val = SW_VERSION;
					end else begin
						dnBad = 1'b1;
					end
				end
				CMD_SNAP: begin
					if (req.dataNo[7:4] == DN_SNAP_LO) begin
						snapSel = {1'b0, req.dataNo[3:0]};
					end else if (req.dataNo[7:4] == DN_SNAP_HI && req.dataNo[3:1] == 3'h0) begin
						snapSel = SNAP_HI_BASE | {4'h0, req.dataNo[0]};
					end else begin
						dnBad = 1'b1;
					end
					next_len = LEN_12;
					next_val = {16'h0, snap[snapSel]};
				end
				CMD_LATCH: begin
					next_len = LEN_8;
					next_val = {32'h0, io.latchPos};
					dnBad = (req.dataNo != DN_LATCH);
				end
				CMD_GEN_R: begin
					next_len = LEN_8;
					next_val = {32'h0, genR[genIdx(req.dataNo)]};
					dnBad = !genOk(req.dataNo);
				end
				CMD_GEN_D: begin
					next_len = LEN_8;
					next_val = {32'h0, genD[genIdx(req.dataNo)]};
					dnBad = !genOk(req.dataNo);
				end
				CMD_GROUP: begin
					next_len = LEN_4;
					next_val = {48'h0, io.group};
					dnBad = (req.dataNo != DN_ZERO);
				end
				CMD_SNAP_CLR: begin
					if (req.dataNo != DN_ZERO) dnBad = 1'b1;
					else if (keyOk) doSnapClr = 1'b1;
					else next_err = ERR_CHAR;
				end
				CMD_ALARM_CLR: begin
					if (req.dataNo != DN_ZERO && req.dataNo != DN_HIST_TIME) dnBad = 1'b1;
					else if (!keyOk) next_err = ERR_CHAR;
					else if (req.dataNo == DN_HIST_TIME) doHistClr = 1'b1;
					else doAlarmRst = 1'b1;
				end
				CMD_PARAM_WR: begin
					doParam = 1'b1;
				end
				CMD_COMM_IN: begin
					if (req.dataNo == DN_COMM_IN) doComm = 1'b1;
					else dnBad = 1'b1;
				end
				default: begin
					next_err = ERR_CMD;
				end
			endcase
			if (dnBad) begin
				next_err = ERR_DN;
				next_len = LEN_NONE;
				next_val = 64'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// response character generation
	// ------------------------------------------------------------
	assign etxPos = POS_DATA + respLen;
	assign lastPos = etxPos + 5'h02;
	assign chkAdd = txValid && txReady && (pos >= POS_STATION) && (pos <= etxPos);

	always_comb begin
		next_pos = pos + 5'h01;
		nibShift = respLen - (next_pos - POS_DATA) - 5'h01;
		shifted = respVal >> {nibShift, 2'b00};
		sumWithEtx = chkSum + CH_ETX;
		if (next_pos == POS_STATION) begin
			next_char = ssd_hex_ascii(stationNo);
		end else if (next_pos == POS_ERR) begin
			next_char = respErr;
		end else if (next_pos < etxPos) begin
			next_char = ssd_hex_ascii(shifted[3:0]);
		end else if (next_pos == etxPos) begin
			next_char = CH_ETX;
		end else if (next_pos == etxPos + 5'h01) begin
			next_char = ssd_hex_ascii(sumWithEtx[7:4]);
		end else begin
			next_char = ssd_hex_ascii(chkSum[3:0]);
		end
	end

	ssd_checksum u_sum (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(accept),
		.add(chkAdd),
		.chr(txChar),
		.sum(chkSum)
	);

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= SSD_IDLE;
			pos <= 5'h00;
			txValid <= 1'b0;
			txChar <= 8'h00;
			reqReady <= 1'b1;
			respErr <= ERR_OK;
			respLen <= LEN_NONE;
			respVal <= 64'h0;
		end else begin
			case (state)
				SSD_IDLE: begin
					if (req.valid) begin
						state <= SSD_SEND;
						pos <= 5'h00;
						txValid <= 1'b1;
						txChar <= CH_STX;
						reqReady <= 1'b0;
						respErr <= alarmActive ? (next_err | CASE_BIT) : next_err;
						respLen <= next_len;
						respVal <= next_val;
					end
				end
				SSD_SEND: begin
					if (txReady) begin
						if (pos == lastPos) begin
							state <= SSD_IDLE;
							txValid <= 1'b0;
							reqReady <= 1'b1;
						end else begin
							pos <= next_pos;
							txChar <= next_char;
						end
					end
				end
				default: begin
					state <= SSD_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// write effects
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			commInput <= COMM_IN_RST;
			paramWe <= 1'b0;
			paramNum <= 8'h00;
			paramVal <= 32'h0;
		end else begin
			paramWe <= paramGo;
			if (paramGo) begin
				paramNum <= req.dataNo;
				paramVal <= req.data;
			end
			if (commGo) commInput <= req.data;
		end
	end

	// ------------------------------------------------------------
	// current alarm, new alarm wins over reset
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			curAlarm <= ALARM_NONE;
			alarmActive <= 1'b0;
		end else if (alarm.evt) begin
			curAlarm <= alarm.code;
			alarmActive <= 1'b1;
		end else if (alarmRstGo) begin
			curAlarm <= ALARM_NONE;
			alarmActive <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// alarm history, newest at index 0
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				histNum[i] <= ALARM_NONE;
				histTime[i] <= 32'h0;
			end
		end else if (alarm.evt) begin
			histNum[0] <= alarm.code;
			histTime[0] <= alarm.stamp;
			for (int i = 1; i < HIST_DEPTH; i++) begin
				histNum[i] <= histClrGo ? ALARM_NONE : histNum[i-1];
				histTime[i] <= histClrGo ? 32'h0 : histTime[i-1];
			end
		end else if (histClrGo) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				histNum[i] <= ALARM_NONE;
				histTime[i] <= 32'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// status snapshot, a load beats a clear
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		for (int i = 0; i < SNAP_DEPTH; i++) begin
			if (sys_rst) snap[i] <= 48'h0;
			else if (snapWe && snapIdx == 5'(i)) snap[i] <= snapVal;
			else if (snapClrGo) snap[i] <= 48'h0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_io_read: assert property (accept && frameOk && req.cmd == CMD_IO_READ && req.dataNo == DN_ZERO
		|=> respLen == LEN_8 && respVal[31:0] == $past(io.inDev)) else $error("io read wrong");
	a_hist_newest: assert property (accept && frameOk && req.cmd == CMD_HIST && req.dataNo == DN_HIST_NUM
		|=> respLen == LEN_4 && respVal[15:0] == $past(histNum[0])) else $error("history read wrong");
	a_version_read: assert property (accept && frameOk && req.cmd == CMD_CUR_ALARM && req.dataNo == DN_VERSION
		|=> respLen == LEN_16 && respVal == SW_VERSION) else $error("version read wrong");
	a_snap_clear: assert property (accept && frameOk && req.cmd == CMD_SNAP_CLR && req.dataNo == DN_ZERO
		&& keyOk && !snapWe |=> snap[0] == 48'h0) else $error("snapshot not cleared");
	a_param_write: assert property (accept && frameOk && req.cmd == CMD_PARAM_WR
		|=> paramWe && paramNum == $past(req.dataNo) ##1 !paramWe) else $error("param write wrong");
	a_comm_write: assert property (accept && frameOk && req.cmd == CMD_COMM_IN && req.dataNo == DN_COMM_IN
		|=> commInput == $past(req.data)) else $error("comm input not applied");
	a_hist_clear: assert property (accept && frameOk && req.cmd == CMD_ALARM_CLR && req.dataNo == DN_HIST_TIME
		&& keyOk && !alarm.evt |=> histNum[5] == ALARM_NONE && histNum[0] == ALARM_NONE) else $error("history kept");
	a_alarm_reset: assert property (accept && frameOk && req.cmd == CMD_ALARM_CLR && req.dataNo == DN_ZERO
		&& keyOk && !alarm.evt |=> !alarmActive && curAlarm == ALARM_NONE) else $error("alarm not reset");
	a_err_case: assert property (accept && alarmActive |=> respErr[5] && respErr != CASE_BIT)
		else $error("error letter not lower case");
	a_sum_low: assert property (state == SSD_SEND && pos == etxPos && txReady
		##1 txReady[*2] |=> txChar == ssd_hex_ascii(chkSum[3:0]) && pos == lastPos) else $error("checksum char wrong");
	a_bad_key: assert property (accept && frameOk && req.cmd == CMD_ALARM_CLR && req.dataNo == DN_ZERO
		&& !keyOk && !alarm.evt |=> alarmActive == $past(alarmActive) && (respErr | CASE_BIT) == (ERR_CHAR | CASE_BIT))
		else $error("bad key accepted");
	a_bad_dn: assert property (accept && frameOk && req.cmd == CMD_IO_READ && req.dataNo == DN_HIST_NUM
		|=> (respErr | CASE_BIT) == (ERR_DN | CASE_BIT) && respLen == LEN_NONE) else $error("bad data number");
	a_frame_start: assert property (accept |=> txValid && txChar == CH_STX && !reqReady)
		else $error("frame did not start");

	c_hist_read: cover property (accept && frameOk && req.cmd == CMD_HIST);
	c_frame_done: cover property (state == SSD_SEND && txReady && pos == lastPos);
	c_alarm_case: cover property (accept && alarmActive);
	c_key_write: cover property (alarmRstGo);

endmodule

// [test/ssd_master_model.sv]
// Purpose: master station model issuing requests and collecting reply characters
// Assumes: one request outstanding at a time
// Notes: stall makes the consumer take a character only every other cycle

`timescale 1ns/1ns

module ssd_master_model
	import ssd_pkg::*;
(
	// clock
	input wire logic clk,
	// request side
	input wire logic reqReady,
	output ssd_req_s req,
	// reply side
	input wire logic txValid,
	input wire logic [7:0] txChar,
	output logic txReady,
	// test control
	input wire logic stall
);
	logic [7:0] rx[$];

	initial begin
		req = '0;
		txReady = 1'b1;
	end

	always @(posedge clk) begin
		txReady <= stall ? ~txReady : 1'b1;
		if (txValid && txReady) begin
			rx.push_back(txChar);
		end
	end

	// hold request until taken, release with changed lines, wait out reply
	task automatic issue(input ssd_req_s r, output bit ok);
		ssd_req_s idle;
		int i;
		rx.delete();
		i = 0;
		@(posedge clk);
		req <= r;
		do begin
			@(posedge clk);
			i++;
		end while (!reqReady && i < 50);
		idle = ~r;
		idle.valid = 1'b0;
		req <= idle;
		for (i = 0; i < 50 && !txValid; i++) @(posedge clk);
		for (i = 0; i < 200 && (txValid || !reqReady); i++) @(posedge clk);
		ok = (i < 200);
	endtask
endmodule

// [test/tb_ssd_command_decoder.sv]
// Purpose: self-checking bench for the servo serial command decoder
// Assumes: master model issues one request at a time
// Notes: expected frames are rebuilt here from the fields sent

`timescale 1ns/1ns

module tb_ssd_command_decoder
	import ssd_pkg::*;
;
	localparam logic [63:0] VER = 64'hFEDCBA9876543210; // arbitrary value
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic stall = 1'b0;
	logic snapWe = 1'b0;
	logic [4:0] snapIdx = 5'h00;
	logic [47:0] snapVal = 48'h0;
	logic [3:0] stationNo = 4'hA;
	ssd_io_s io = {32'h10203040, 32'h50607080, 32'h90A0B0C0, 32'hD0E0F001, 32'h89ABCDEF, 16'h000C};
	logic [3:0][31:0] genR = {32'h04040404, 32'h03030303, 32'h02020202, 32'h01010101};
	logic [3:0][31:0] genD = {32'hD4D4D4D4, 32'hD3D3D3D3, 32'hD2D2D2D2, 32'hD1D1D1D1};
	ssd_alarm_s alarm = '0;
	ssd_req_s req;
	logic reqReady, txValid, txReady, paramWe, alarmActive;
	logic [7:0] txChar, paramNum;
	logic [31:0] commInput, paramVal;
	int errors = 0;
	int n_compared = 0;
	int nPw = 0;
	bit alm = 0;

	always #5 clk = ~clk;
	always @(posedge clk) if (paramWe) nPw++;

	ssd_command_decoder #(.SW_VERSION(VER)) i_dut (.clk(clk), .sys_rst(sysRst), .req(req),
		.reqReady(reqReady), .io(io), .genR(genR), .genD(genD), .alarm(alarm),
		.snapWe(snapWe), .snapIdx(snapIdx), .snapVal(snapVal), .stationNo(stationNo),
		.txReady(txReady), .txValid(txValid), .txChar(txChar), .commInput(commInput),
		.paramWe(paramWe), .paramNum(paramNum), .paramVal(paramVal), .alarmActive(alarmActive));
	ssd_master_model i_master (.clk(clk), .reqReady(reqReady), .req(req), .txValid(txValid),
		.txChar(txChar), .txReady(txReady), .stall(stall));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n > 4'h9) ? 8'h37 + {4'h0, n} : 8'h30 + {4'h0, n};
	endfunction

	function automatic logic [47:0] sv(input int k);
		return {16'h5000 + 16'(k), 32'h12340000 + 32'(k)};
	endfunction

	// one request, whole reply compared with the frame built here
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dn, input logic [31:0] data,
			input logic [2:0] fl, input logic [7:0] ltr, input int n, input logic [63:0] val);
		logic [7:0] e[$];
		logic [7:0] s;
		bit ok;
		int i;
		i_master.issue({1'b1, cmd, dn, data, fl}, ok);
		chk(ok, 1);
		e = {CH_STX, hx(stationNo), alm ? (ltr | CASE_BIT) : ltr};
		for (i = n - 1; i >= 0; i--) e.push_back(hx(val[i*4 +: 4]));
		e.push_back(CH_ETX);
		s = 8'h00;
		for (i = 1; i < e.size(); i++) s += e[i];
		e.push_back(hx(s[7:4]));
		e.push_back(hx(s[3:0]));
		chk(i_master.rx.size(), e.size());
		foreach (e[k]) chk(i_master.rx[k], e[k]);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_io();
		logic [7:0] dns[5] = '{DN_ZERO, DN_IN_PIN, DN_COMM_IN, DN_OUT_DEV, DN_OUT_PIN};
		logic [31:0] ex[5] = '{io.inDev, io.inPin, 32'h5A5A0F0F, io.outDev, io.outPin};
		xfer(CMD_COMM_IN, DN_COMM_IN, 32'h5A5A0F0F, 0, ERR_OK, 0, 0);
		chk(commInput, 32'h5A5A0F0F);
		xfer(CMD_COMM_IN, 8'h61, 32'h1, 0, ERR_DN, 0, 0);
		chk(commInput, 32'h5A5A0F0F);
		for (int k = 0; k < 5; k++) xfer(CMD_IO_READ, dns[k], 0, 0, ERR_OK, 8, ex[k]);
		$display("test io done");
	endtask

	task automatic t_alarm();
		for (int k = 1; k <= 7; k++) begin
			@(posedge clk);
			alarm <= {1'b1, 16'h0100 + 16'(k), 32'hA0000000 + 32'(k)};
			@(posedge clk);
			alarm.evt <= 1'b0;
		end
		repeat (2) @(posedge clk);
		alm = 1;
		chk(alarmActive, 1);
		xfer(CMD_CUR_ALARM, DN_ZERO, 0, 0, ERR_OK, 4, 64'h0107);
		for (int k = 0; k < HIST_DEPTH; k++) begin
			xfer(CMD_HIST, DN_HIST_NUM + 8'(k), 0, 0, ERR_OK, 4, 64'h0107 - k);
			xfer(CMD_HIST, DN_HIST_TIME + 8'(k), 0, 0, ERR_OK, 8, 64'hA0000007 - k);
		end
		xfer(CMD_ALARM_CLR, DN_ZERO, 32'h1EA4, 0, ERR_CHAR, 0, 0);
		chk(alarmActive, 1);
		xfer(CMD_ALARM_CLR, DN_ZERO, CLEAR_KEY, 0, ERR_OK, 0, 0);
		alm = 0;
		chk(alarmActive, 0);
		xfer(CMD_CUR_ALARM, DN_ZERO, 0, 0, ERR_OK, 4, 0);
		xfer(CMD_ALARM_CLR, DN_HIST_TIME, 32'hA51E, 0, ERR_CHAR, 0, 0);
		xfer(CMD_HIST, DN_HIST_NUM, 0, 0, ERR_OK, 4, 64'h0107);
		xfer(CMD_ALARM_CLR, DN_HIST_TIME, CLEAR_KEY, 0, ERR_OK, 0, 0);
		xfer(CMD_HIST, DN_HIST_NUM + 8'h05, 0, 0, ERR_OK, 4, 0);
		xfer(CMD_HIST, DN_HIST_TIME, 0, 0, ERR_OK, 8, 0);
		$display("test alarm done");
	endtask

	task automatic t_snap();
		for (int k = 0; k < SNAP_DEPTH; k++) begin
			@(posedge clk);
			snapWe <= 1'b1;
			snapIdx <= 5'(k);
			snapVal <= sv(k);
		end
		@(posedge clk);
		snapWe <= 1'b0;
		for (int k = 0; k < SNAP_DEPTH; k++) xfer(CMD_SNAP, 8'h80 + 8'(k), 0, 0, ERR_OK, 12, sv(k));
		xfer(CMD_SNAP_CLR, DN_ZERO, 32'h0000, 0, ERR_CHAR, 0, 0);
		xfer(CMD_SNAP, 8'h91, 0, 0, ERR_OK, 12, sv(17));
		xfer(CMD_SNAP_CLR, DN_ZERO, CLEAR_KEY, 0, ERR_OK, 0, 0);
		xfer(CMD_SNAP, 8'h80, 0, 0, ERR_OK, 12, 0);
		xfer(CMD_SNAP, 8'h91, 0, 0, ERR_OK, 12, 0);
		$display("test snapshot done");
	endtask

	task automatic t_misc();
		int pw;
		xfer(CMD_LATCH, DN_LATCH, 0, 0, ERR_OK, 8, io.latchPos);
		for (int k = 0; k < GEN_DEPTH; k++) begin
			xfer(CMD_GEN_R, 8'(k + 1), 0, 0, ERR_OK, 8, genR[k]);
			xfer(CMD_GEN_D, 8'(k + 1), 0, 0, ERR_OK, 8, genD[k]);
		end
		xfer(CMD_GROUP, DN_ZERO, 0, 0, ERR_OK, 4, io.group);
		stall <= 1'b1;
		xfer(CMD_CUR_ALARM, DN_VERSION, 0, 0, ERR_OK, 16, VER);
		stall <= 1'b0;
		pw = nPw;
		xfer(CMD_PARAM_WR, 8'h5A, 32'h3C5A0123, 0, ERR_OK, 0, 0);
		chk(nPw - pw, 1);
		chk(paramNum, 8'd90);
		chk(paramVal, 32'h3C5A0123);
		$display("test misc done");
	endtask

	task automatic t_err();
		xfer(CMD_IO_READ, DN_ZERO, 0, 3'b100, ERR_PARITY, 0, 0);
		xfer(CMD_IO_READ, DN_ZERO, 0, 3'b010, ERR_SUM, 0, 0);
		xfer(CMD_IO_READ, DN_ZERO, 0, 3'b001, ERR_CHAR, 0, 0);
		xfer(CMD_IO_READ, DN_ZERO, 0, 3'b111, ERR_PARITY, 0, 0);
		xfer(8'h77, DN_ZERO, 0, 0, ERR_CMD, 0, 0);
		xfer(CMD_HIST, 8'h16, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_GEN_R, 8'h05, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_IO_READ, DN_HIST_NUM, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_SNAP, 8'h92, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_LATCH, DN_ZERO, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_GROUP, DN_LATCH, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_CUR_ALARM, DN_LATCH, 0, 0, ERR_DN, 0, 0);
		xfer(CMD_SNAP_CLR, DN_LATCH, CLEAR_KEY, 0, ERR_DN, 0, 0);
		xfer(CMD_ALARM_CLR, DN_LATCH, CLEAR_KEY, 0, ERR_DN, 0, 0);
		$display("test errors done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		sysRst <= 1'b0;
		t_io();
		t_alarm();
		t_snap();
		t_misc();
		t_err();
		end_sim();
	end

	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule
